// ---- hw/fcg_pkg.sv ----
// Package of constants, states and carrier types for the clock generator mode logic.
package fcg_pkg;

  // ---------------------------------------------------------------------------
  // Clock rate and register map
  // ---------------------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 250000;
  localparam int SYS_CLK_MHZ = 250;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DCO = 8'h0c;
  localparam logic [7:0] OFS_TRIM = 8'h10;

  // ---------------------------------------------------------------------------
  // Timing figures and the cycle counts derived from them
  // ---------------------------------------------------------------------------
  localparam int INT_REF_KHZ = 243;
  localparam logic [10:0] INT_REF_CYC = 11'(SYS_CLK_KHZ / INT_REF_KHZ);
  localparam int DBG_CLK_KHZ = 8000;
  localparam logic [4:0] DBG_HALF_CYC = 5'(SYS_CLK_KHZ / (2 * DBG_CLK_KHZ));
  localparam int EXT_LOSS_NS = 20000;
  localparam int RTI_HALF_NS = 500000;
  localparam int FLL_MIN_KHZ = 8000;
  localparam int FLL_MAX_KHZ = 40000;
  localparam longint DCO_SCALE = 131072;
  localparam logic [15:0] DCO_MIN_INC =
    16'((longint'(FLL_MIN_KHZ) * DCO_SCALE + SYS_CLK_KHZ - 1) / SYS_CLK_KHZ);
  localparam logic [15:0] DCO_MAX_INC =
    16'((longint'(FLL_MAX_KHZ) * DCO_SCALE) / SYS_CLK_KHZ);

  // ---------------------------------------------------------------------------
  // Reset values and loop constants
  // ---------------------------------------------------------------------------
  localparam logic [15:0] DCO_RESET_INC = 16'h2000;
  localparam logic [15:0] DCO_STEP = 16'h0010;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [10:0] TRIM_MID = 11'h080;
  localparam logic [7:0] MULT_RESET = 8'h40;
  localparam logic [2:0] DIV_RESET = 3'h1;
  localparam logic [2:0] EXT_GOOD_EDGES = 3'h4;
  localparam logic [8:0] LOCK_TOL = 9'h001;
  localparam logic [8:0] UNLOCK_TOL = 9'h003;
  localparam logic [2:0] LOCK_WINDOWS = 3'h4;
  localparam logic [8:0] MEAS_MAX = 9'h1ff;

  // ---------------------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SELF = 2'b00,
    MODE_INT = 2'b01,
    MODE_BYPASS = 2'b10,
    MODE_EXT = 2'b11
  } fcg_mode_sel_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SELF_CLOCKED = 3'b001,
    ST_INT_UNLOCKED = 3'b010,
    ST_INT_LOCKED = 3'b011,
    ST_BYPASS_EXT = 3'b100,
    ST_EXT_UNLOCKED = 3'b101,
    ST_EXT_LOCKED = 3'b110
  } fcg_state_t;

  typedef enum logic [1:0] {
    SRC_DCO = 2'b00,
    SRC_EXT = 2'b01,
    SRC_REF8 = 2'b10
  } fcg_src_t;

  // ---------------------------------------------------------------------------
  // Register layouts and carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic loss_reset_sel;
    logic loss_detect_off;
    logic range_select;
    logic high_gain_select;
    fcg_mode_sel_t clock_mode_select;
  } fcg_ctrl_t;

  typedef struct packed {
    logic [7:0] fll_mult;
    logic [2:0] post_div;
  } fcg_freq_t;

  typedef struct packed {
    logic ext_ref_valid_status;
    logic fll_locked;
    logic loss_clk_flag;
    logic loss_lock_flag;
    fcg_state_t state;
  } fcg_status_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fcg_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fcg_apb_rsp_t;

  typedef struct packed {
    logic gen_output_clock;
    logic fll_multiplied_clock;
    logic external_ref_clock;
    logic debug_local_clock;
    logic fixed_freq_enable;
    logic rti_clock;
  } fcg_clk_out_t;

endpackage

// ---- hw/fcg_clock_gen_unit.sv ----
// Mode control, FLL model, post divider and clock monitor of the clock generator.
//
// Overview of operation
// - Reset enters self-clocked mode, DIGITAL_CONTROLLED_OSC free-running
// - Off mode holds output clock static
// - Internal FLL mode multiplies internal reference
// - Unlocked state adjusts DIGITAL_CONTROLLED_OSC until lock
// - Bypass mode routes external clock directly
// - External FLL mode multiplies external reference
// - Post divider divides by 1 to 128
// - FLL output limited to 8-40 MHz
// - Loss of clock/lock requests reset or interrupt
// - DIGITAL_CONTROLLED_OSC setting kept through stop
// - DIGITAL_CONTROLLED_OSC holds frequency when reference lost
// - Output switches to FLL after lock
// - Non-running clock sources are never selected
// - Status shows lock and loss of lock
// - External reference monitored, valid status shown
// - Internal 8 MHz and trimmable 243 kHz references
// - Range and high-gain selects exposed
// - Fixed-frequency enable produced with clocks
// - Separate self-clocked real-time interrupt clock
// - Mode field encodes four clock modes
// - Bypass mode waits for valid external clock
`timescale 1ns/1ps
module fcg_clock_gen_unit #(
  parameter int EXT_LOSS_CYC = fcg_pkg::EXT_LOSS_NS * fcg_pkg::SYS_CLK_MHZ / 1000,
  parameter int RTI_HALF_CYC = fcg_pkg::RTI_HALF_NS * fcg_pkg::SYS_CLK_MHZ / 1000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fcg_pkg::fcg_apb_req_t apb_req,
  output fcg_pkg::fcg_apb_rsp_t apb_rsp,
  input wire logic stop_req,
  input wire logic ext_ref_pin,
  output fcg_pkg::fcg_clk_out_t clk_out,
  output logic high_gain_select,
  output logic range_select,
  output logic reset_req,
  output logic irq_req
);

  // ---------------------------------------------------------------------------
  // State of the block
  // ---------------------------------------------------------------------------
  typedef struct packed {
    fcg_pkg::fcg_apb_rsp_t rsp;
    fcg_pkg::fcg_ctrl_t ctrl;
    logic cfg_written;
    fcg_pkg::fcg_freq_t freq;
    logic [15:0] dco_inc;
    logic [7:0] trim;
    fcg_pkg::fcg_state_t state;
    logic sync1;
    logic sync2;
    logic sync3;
    logic ext_stable;
    logic [16:0] ext_idle;
    logic [2:0] ext_edges;
    logic ext_valid;
    logic [15:0] dco_acc;
    logic dco_clk;
    logic [10:0] ref_cnt;
    logic [4:0] dbg_cnt;
    logic dbg_clk;
    logic [16:0] rti_cnt;
    logic rti_clk;
    logic [8:0] meas_cnt;
    logic [2:0] lock_cnt;
    logic locked;
    logic loss_clk_flag;
    logic loss_lock_flag;
    fcg_pkg::fcg_src_t sel_act;
    logic [2:0] div_act;
    logic [6:0] div_cnt;
    logic out_clk;
    logic ffe;
    logic reset_req;
    logic irq_req;
  } fcg_regs_t;

  fcg_regs_t st;
  fcg_regs_t n;
  fcg_pkg::fcg_status_t sts;
  fcg_pkg::fcg_status_t wsts;
  fcg_pkg::fcg_ctrl_t wctrl;
  fcg_pkg::fcg_src_t want;
  logic wr_en;
  logic setup;
  logic ext_evt;
  logic ext_rise;
  logic int_tick;
  logic ref8_evt;
  logic ref_evt;
  logic dco_evt;
  logic src_evt;
  logic ext_kind;
  logic engaged;
  logic hold;
  logic set_clk;
  logic set_lock;
  logic [16:0] dco_sum;
  logic [10:0] ref_period;
  logic [8:0] dif;

  // Divider terminal count: the output toggles every 2^d source half periods.
  function automatic logic [6:0] div_top(input logic [2:0] d);
    logic [7:0] w;
    w = (8'h01 << d) - 8'h01;
    return w[6:0];
  endfunction

  // Limits a DIGITAL_CONTROLLED_OSC setting to the legal FLL output range.
  function automatic logic [15:0] dco_clamp(input logic [16:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > {1'b0, fcg_pkg::DCO_MAX_INC})
      r = fcg_pkg::DCO_MAX_INC;
    else if (v < {1'b0, fcg_pkg::DCO_MIN_INC})
      r = fcg_pkg::DCO_MIN_INC;
    return r;
  endfunction

  // Distance between the measured and the programmed edge count.
  function automatic logic [8:0] abs_diff(input logic [8:0] a, input logic [8:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Computes the complete next state of the block in one pass.
  always_comb
  begin
    n = st;
    sts = '{st.ext_valid, st.locked, st.loss_clk_flag, st.loss_lock_flag, st.state};
    wsts = fcg_pkg::fcg_status_t'(apb_req.pwdata[$bits(fcg_pkg::fcg_status_t)-1:0]);
    wctrl = fcg_pkg::fcg_ctrl_t'(apb_req.pwdata[$bits(fcg_pkg::fcg_ctrl_t)-1:0]);
    setup = apb_req.psel && !apb_req.penable;
    wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && st.rsp.pready;
    set_clk = 1'b0;
    set_lock = 1'b0;
    want = fcg_pkg::SRC_DCO;

    // Register bus: answer in the first access cycle, read data sampled at setup.
    n.rsp.pready = setup;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata = '0;
    if (setup)
    begin
      if (apb_req.paddr == fcg_pkg::OFS_CTRL)
        n.rsp.prdata = 32'(st.ctrl);
      else if (apb_req.paddr == fcg_pkg::OFS_FREQ)
        n.rsp.prdata = 32'(st.freq);
      else if (apb_req.paddr == fcg_pkg::OFS_STATUS)
        n.rsp.prdata = 32'(sts);
      else if (apb_req.paddr == fcg_pkg::OFS_DCO)
        n.rsp.prdata = 32'(st.dco_inc);
      else if (apb_req.paddr == fcg_pkg::OFS_TRIM)
        n.rsp.prdata = 32'(st.trim);
      else
        n.rsp.pslverr = 1'b1;
    end

    // Register writes; gain and range are taken only from the first control register write.
    if (wr_en && apb_req.paddr == fcg_pkg::OFS_CTRL)
    begin
      n.ctrl.clock_mode_select = wctrl.clock_mode_select;
      n.ctrl.loss_detect_off = wctrl.loss_detect_off;
      n.ctrl.loss_reset_sel = wctrl.loss_reset_sel;
      if (!st.cfg_written)
      begin
        n.ctrl.high_gain_select = wctrl.high_gain_select;
        n.ctrl.range_select = wctrl.range_select;
        n.cfg_written = 1'b1;
      end
    end
    if (wr_en && apb_req.paddr == fcg_pkg::OFS_FREQ)
      n.freq = fcg_pkg::fcg_freq_t'(apb_req.pwdata[$bits(fcg_pkg::fcg_freq_t)-1:0]);
    if (wr_en && apb_req.paddr == fcg_pkg::OFS_DCO)
      n.dco_inc = dco_clamp({1'b0, apb_req.pwdata[15:0]});
    if (wr_en && apb_req.paddr == fcg_pkg::OFS_TRIM)
      n.trim = apb_req.pwdata[7:0];

    // External reference: three-stage synchroniser, edge count and idle timeout.
    n.sync1 = ext_ref_pin;
    n.sync2 = st.sync1;
    n.sync3 = st.sync2;
    ext_evt = (st.sync2 == st.sync3) && (st.sync3 != st.ext_stable);
    ext_rise = ext_evt && st.sync3;
    if (ext_evt)
    begin
      n.ext_stable = st.sync3;
      n.ext_idle = '0;
      if (st.ext_edges != fcg_pkg::EXT_GOOD_EDGES)
        n.ext_edges = st.ext_edges + 3'h1;
    end
    else if (st.ext_idle == 17'(EXT_LOSS_CYC - 1))
      n.ext_edges = '0;
    else
      n.ext_idle = st.ext_idle + 17'h00001;
    n.ext_valid = (n.ext_edges == fcg_pkg::EXT_GOOD_EDGES);
    set_clk = st.ext_valid && !n.ext_valid && !st.ctrl.loss_detect_off &&
      (st.ctrl.clock_mode_select == fcg_pkg::MODE_BYPASS ||
       st.ctrl.clock_mode_select == fcg_pkg::MODE_EXT);

    // Internal references: trimmable low reference, 8 MHz debug clock, RTI clock.
    ref_period = fcg_pkg::INT_REF_CYC + {3'h0, st.trim} - fcg_pkg::TRIM_MID;
    int_tick = (st.ref_cnt >= ref_period - 11'h001);
    n.ref_cnt = int_tick ? '0 : st.ref_cnt + 11'h001;
    ref8_evt = (st.dbg_cnt == fcg_pkg::DBG_HALF_CYC - 5'h01);
    n.dbg_cnt = ref8_evt ? '0 : st.dbg_cnt + 5'h01;
    n.dbg_clk = st.dbg_clk ^ ref8_evt;
    if (st.rti_cnt == 17'(RTI_HALF_CYC - 1))
    begin
      n.rti_cnt = '0;
      n.rti_clk = !st.rti_clk;
    end
    else
      n.rti_cnt = st.rti_cnt + 17'h00001;

    // DIGITAL_CONTROLLED_OSC: phase accumulator that stops, but keeps its setting, in off mode.
    dco_sum = {1'b0, st.dco_acc} + {1'b0, st.dco_inc};
    dco_evt = (st.state != fcg_pkg::ST_OFF) && dco_sum[16];
    if (st.state != fcg_pkg::ST_OFF)
      n.dco_acc = dco_sum[15:0];
    n.dco_clk = st.dco_clk ^ dco_evt;

    // FLL: count DIGITAL_CONTROLLED_OSC rising edges per reference period and steer the DIGITAL_CONTROLLED_OSC.
    ext_kind = (st.state == fcg_pkg::ST_EXT_UNLOCKED) ||
      (st.state == fcg_pkg::ST_EXT_LOCKED) || (st.state == fcg_pkg::ST_BYPASS_EXT);
    engaged = (st.state == fcg_pkg::ST_INT_UNLOCKED) || (st.state == fcg_pkg::ST_INT_LOCKED) ||
      (st.state == fcg_pkg::ST_EXT_UNLOCKED) || (st.state == fcg_pkg::ST_EXT_LOCKED);
    ref_evt = ext_kind ? ext_rise : int_tick;
    hold = ext_kind && !st.ext_valid;
    dif = abs_diff(st.meas_cnt, {1'b0, st.freq.fll_mult});
    if (!engaged)
    begin
      n.meas_cnt = '0;
      n.lock_cnt = '0;
      n.locked = 1'b0;
    end
    else if (hold)
      n.meas_cnt = '0;
    else if (ref_evt)
    begin
      n.meas_cnt = '0;
      if (dif > fcg_pkg::LOCK_TOL && st.meas_cnt < {1'b0, st.freq.fll_mult})
        n.dco_inc = dco_clamp({1'b0, st.dco_inc} + {1'b0, fcg_pkg::DCO_STEP});
      else if (dif > fcg_pkg::LOCK_TOL)
        n.dco_inc = dco_clamp({1'b0, st.dco_inc} - {1'b0, fcg_pkg::DCO_STEP});
      if (dif <= fcg_pkg::LOCK_TOL)
      begin
        if (st.lock_cnt != fcg_pkg::LOCK_WINDOWS)
          n.lock_cnt = st.lock_cnt + 3'h1;
        if (st.lock_cnt == fcg_pkg::LOCK_WINDOWS - 3'h1)
          n.locked = 1'b1;
      end
      else
      begin
        n.lock_cnt = '0;
        if (dif > fcg_pkg::UNLOCK_TOL && st.locked)
        begin
          n.locked = 1'b0;
          set_lock = !st.ctrl.loss_detect_off;
        end
      end
    end
    else if (dco_evt && !st.dco_clk && st.meas_cnt != fcg_pkg::MEAS_MAX)
      n.meas_cnt = st.meas_cnt + 9'h001;

    // Mode sequencing from the mode field, stop request and lock status.
    if (stop_req)
      n.state = fcg_pkg::ST_OFF;
    else
    begin
      case (st.ctrl.clock_mode_select)
        fcg_pkg::MODE_SELF:
          n.state = fcg_pkg::ST_SELF_CLOCKED;
        fcg_pkg::MODE_INT:
          if (n.locked && !ext_kind)
            n.state = fcg_pkg::ST_INT_LOCKED;
          else
            n.state = fcg_pkg::ST_INT_UNLOCKED;
        fcg_pkg::MODE_BYPASS:
          if (st.ext_valid)
            n.state = fcg_pkg::ST_BYPASS_EXT;
          else if (st.state == fcg_pkg::ST_BYPASS_EXT || st.state == fcg_pkg::ST_OFF)
            n.state = fcg_pkg::ST_SELF_CLOCKED;
        default:
          if (n.locked && ext_kind)
            n.state = fcg_pkg::ST_EXT_LOCKED;
          else
            n.state = fcg_pkg::ST_EXT_UNLOCKED;
      endcase
    end
    // Lock is reported only while the block sits in a locked state.
    if (n.state != fcg_pkg::ST_INT_LOCKED && n.state != fcg_pkg::ST_EXT_LOCKED)
      n.locked = 1'b0;

    // Source wanted: safe 8 MHz reference while unlocked, DIGITAL_CONTROLLED_OSC once locked.
    case (n.state)
      fcg_pkg::ST_BYPASS_EXT:
        want = fcg_pkg::SRC_EXT;
      fcg_pkg::ST_INT_UNLOCKED, fcg_pkg::ST_EXT_UNLOCKED:
        want = fcg_pkg::SRC_REF8;
      default:
        want = fcg_pkg::SRC_DCO;
    endcase

    // Post divider; the source and divisor change as the output falls, the source also at once when a selected external clock is lost.
    case (st.sel_act)
      fcg_pkg::SRC_EXT:
        src_evt = ext_evt;
      fcg_pkg::SRC_REF8:
        src_evt = ref8_evt;
      default:
        src_evt = dco_evt;
    endcase
    if (st.state != fcg_pkg::ST_OFF && src_evt)
    begin
      if (st.div_cnt >= div_top(st.div_act))
      begin
        n.div_cnt = '0;
        n.out_clk = !st.out_clk;
        if (st.out_clk)
        begin
          n.sel_act = want;
          n.div_act = st.freq.post_div;
        end
      end
      else
        n.div_cnt = st.div_cnt + 7'h01;
    end
    if (st.sel_act == fcg_pkg::SRC_EXT && !st.ext_valid)
    begin
      n.sel_act = want;
      n.div_cnt = '0;
    end

    // Fixed-frequency enable follows the reference in use.
    n.ffe = ref_evt && st.state != fcg_pkg::ST_OFF;

    // Sticky loss flags: write one to clear, a new event wins over the clear.
    n.loss_clk_flag = (st.loss_clk_flag &&
      !(wr_en && apb_req.paddr == fcg_pkg::OFS_STATUS && wsts.loss_clk_flag)) || set_clk;
    n.loss_lock_flag = (st.loss_lock_flag &&
      !(wr_en && apb_req.paddr == fcg_pkg::OFS_STATUS && wsts.loss_lock_flag)) || set_lock;
    n.reset_req = n.ctrl.loss_reset_sel && (n.loss_clk_flag || n.loss_lock_flag);
    n.irq_req = !n.ctrl.loss_reset_sel && (n.loss_clk_flag || n.loss_lock_flag);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Registers the next state; reset starts in self-clocked mode.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.state <= fcg_pkg::ST_SELF_CLOCKED;
      st.dco_inc <= fcg_pkg::DCO_RESET_INC;
      st.trim <= fcg_pkg::TRIM_RESET;
      st.freq.fll_mult <= fcg_pkg::MULT_RESET;
      st.freq.post_div <= fcg_pkg::DIV_RESET;
      st.div_act <= fcg_pkg::DIV_RESET;
    end
    else
      st <= n;
  end

  // Outputs come straight from the state register.
  assign apb_rsp = st.rsp;
  assign clk_out = '{st.out_clk, st.dco_clk, st.ext_stable, st.dbg_clk, st.ffe, st.rti_clk};
  assign high_gain_select = st.ctrl.high_gain_select;
  assign range_select = st.ctrl.range_select;
  assign reset_req = st.reset_req;
  assign irq_req = st.irq_req;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking ast_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_OFF_STATIC: assert property (
    (st.state == fcg_pkg::ST_OFF) |=> $stable(st.out_clk))
    else $error("Output clock moved in off mode.");
  AST_DIV_RANGE: assert property (
    st.div_cnt <= div_top(st.div_act))
    else $error("Post divider count beyond its divisor.");
  AST_DCO_LIMITS: assert property (
    st.dco_inc >= fcg_pkg::DCO_MIN_INC && st.dco_inc <= fcg_pkg::DCO_MAX_INC)
    else $error("DIGITAL_CONTROLLED_OSC setting outside the FLL output range.");
  AST_LOSS_REQ: assert property (
    $rose(st.loss_clk_flag) || $rose(st.loss_lock_flag) |-> st.reset_req || st.irq_req)
    else $error("Loss event raised no reset or interrupt request.");
  AST_DCO_KEEP_OFF: assert property (
    (st.state == fcg_pkg::ST_OFF) [*2] |-> $stable(st.dco_inc) && $stable(st.dco_acc))
    else $error("DIGITAL_CONTROLLED_OSC setting changed in off mode.");
  AST_DCO_HOLD_LOST: assert property (
    (st.state == fcg_pkg::ST_EXT_UNLOCKED && !st.ext_valid) |=> $stable(st.dco_inc))
    else $error("DIGITAL_CONTROLLED_OSC moved while the reference was lost.");
  AST_DEAD_SOURCE: assert property (
    (st.sel_act == fcg_pkg::SRC_EXT && !st.ext_valid) |=> st.sel_act != fcg_pkg::SRC_EXT)
    else $error("Stopped external clock stayed selected.");
  AST_BYPASS_VALID: assert property (
    (st.state == fcg_pkg::ST_BYPASS_EXT) |-> $past(st.ext_valid))
    else $error("Bypass mode entered without a valid external clock.");
  AST_LOCK_STATE: assert property (
    st.locked |-> (st.state == fcg_pkg::ST_INT_LOCKED || st.state == fcg_pkg::ST_EXT_LOCKED))
    else $error("Lock flag set outside a locked state.");

endmodule

// ---- verif/fcg_ext_src.sv ----
// Behavioural external square-wave reference source.
`timescale 1ns/1ps
module fcg_ext_src #(
  parameter realtime HALF_NS = 50.3
) (
  input wire logic run,
  output logic pin
);
  logic lvl = 1'b0;

  // Toggles only while running, at a rate unrelated to the system clock.
  always
  begin
    #(HALF_NS);
    if (run)
      lvl = ~lvl;
  end

  // A stopped source rests at the inverse of its last level.
  assign pin = run ? lvl : ~lvl;
endmodule

// ---- verif/fcg_clock_gen_unit_tb_top.sv ----
// Self-checking bench for the clock generator mode logic.
`timescale 1ns/1ps
module fcg_clock_gen_unit_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic stop_req = 1'b0;
  logic ext_run = 1'b0;
  logic ext_ref_pin;
  logic high_gain_select;
  logic range_select;
  logic reset_req;
  logic irq_req;
  fcg_pkg::fcg_apb_req_t apb_req = '0;
  fcg_pkg::fcg_apb_rsp_t apb_rsp;
  fcg_pkg::fcg_clk_out_t clk_out;
  int fails = 0;
  int checks = 0;
  int n;
  logic [31:0] r;
  logic e;

  fcg_clock_gen_unit #(.EXT_LOSS_CYC(64), .RTI_HALF_CYC(16)) u_fcg_clock_gen_unit (
    .sys_clk(sys_clk),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .stop_req(stop_req),
    .ext_ref_pin(ext_ref_pin),
    .clk_out(clk_out),
    .high_gain_select(high_gain_select),
    .range_select(range_select),
    .reset_req(reset_req),
    .irq_req(irq_req)
  );

  fcg_ext_src u_fcg_ext_src (
    .run(ext_run),
    .pin(ext_ref_pin)
  );

  // The system clock runs at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask

  // One APB transfer, entered just after a rising edge; data is taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    logic done;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge sys_clk);
      done = (apb_rsp.pready === 1'b1);
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge sys_clk);
  endtask

  // Register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic x;
    apb(1'b1, a, d, q, x);
  endtask

  // Register read with the selected bits compared.
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] x);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    chk(nm, q & m, x);
  endtask

  // Measures cycles between two toggles of one output clock bit.
  task automatic half(input int b, output int c);
    logic v;
    @(negedge sys_clk);
    for (int k = 0; k < 2; k++)
    begin
      v = clk_out[b];
      c = 0;
      while (clk_out[b] === v && c < 1000)
      begin
        @(negedge sys_clk);
        c++;
      end
    end
    @(posedge sys_clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  // Resets the block, then works through the scenarios in order.
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk("reset state", 8'h08, 32'h7f, 32'h01);
    rdchk("reset freq", 8'h04, 32'hffffffff, 32'h201);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
    half(2, n);
    chk("debug half", n, 15);
    half(0, n);
    chk("rti half", n, 16);
    wr(8'h00, 32'h6);
    repeat (100) @(posedge sys_clk);
    rdchk("bypass held", 8'h08, 32'h7, 32'h1);
    chk("high gain", 32'(high_gain_select), 32'h1);
    ext_run <= 1'b1;
    repeat (400) @(posedge sys_clk);
    rdchk("bypass state", 8'h08, 32'h7, 32'h4);
    rdchk("ext valid", 8'h08, 32'h40, 32'h40);
    ext_run <= 1'b0;
    repeat (200) @(posedge sys_clk);
    rdchk("loss status", 8'h08, 32'h57, 32'h11);
    chk("loss irq", 32'(irq_req), 32'h1);
    chk("loss reset", 32'(reset_req), 32'h0);
    wr(8'h08, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'(irq_req), 32'h0);
    wr(8'h00, 32'h1);
    r = 32'h0;
    for (int i = 0; i < 300 && r[5] !== 1'b1; i++)
    begin
      repeat (100) @(posedge sys_clk);
      apb(1'b0, 8'h08, 32'h0, r, e);
    end
    chk("locked status", r & 32'h27, 32'h23);
    repeat (100) @(posedge sys_clk);
    half(5, n);
    chk("locked source", 32'(n < 20), 32'h1);
    ext_run <= 1'b1;
    wr(8'h00, 32'h3);
    repeat (200) @(posedge sys_clk);
    rdchk("ext fll state", 8'h08, 32'h47, 32'h45);
    ext_run <= 1'b0;
    repeat (200) @(posedge sys_clk);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    repeat (100) @(posedge sys_clk);
    rdchk("dco held", 8'h0c, 32'hffff, r);
    rdchk("ext loss status", 8'h08, 32'h57, 32'h15);
    stop_req <= 1'b1;
    repeat (4) @(negedge sys_clk);
    e = clk_out.gen_output_clock;
    n = 0;
    repeat (40)
    begin
      @(negedge sys_clk);
      n += int'(clk_out.gen_output_clock !== e);
    end
    @(posedge sys_clk);
    chk("off clock moves", n, 0);
    rdchk("off state", 8'h08, 32'h7, 32'h0);
    stop_req <= 1'b0;
    @(posedge sys_clk);
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h0);
    rdchk("dco low clamp", 8'h0c, 32'hffff, 32'd4195);
    wr(8'h0c, 32'hffff);
    rdchk("dco high clamp", 8'h0c, 32'hffff, 32'd20971);
    end_sim();
  end

  // Cuts a hang short after well beyond the expected run length.
  initial
  begin
    #320000;
    fails++;
    end_sim();
  end
endmodule
